// File: src/sbps_pkg.sv
// package for the sixteen bit parallel/serial-in shift register
// assumes a single core clock domain; pins arrive asynchronously
package sbps_pkg;

    localparam int unsigned SBPS_WIDTH      = 16;
    localparam int unsigned SBPS_LAST_STAGE = 15;
    localparam int unsigned SBPS_SYNC_DEPTH = 2;

    // reset values of the pin synchronisers (inactive levels)
    localparam logic SBPS_CS_RST   = 1'h1;
    localparam logic SBPS_CLK_RST  = 1'h0;
    localparam logic SBPS_LOAD_RST = 1'h0;
    localparam logic SBPS_SER_RST  = 1'h0;

    // control pins as one bundle
    typedef struct packed {
        logic chip_select_n;
        logic load_select;
        logic falling_edge_clock;
        logic serial_in;
    } sbps_ctrl_t;

    localparam sbps_ctrl_t SBPS_CTRL_RST = '{
        chip_select_n      : SBPS_CS_RST,
        load_select        : SBPS_LOAD_RST,
        falling_edge_clock : SBPS_CLK_RST,
        serial_in          : SBPS_SER_RST
    };

    typedef logic [SBPS_WIDTH-1:0] sbps_word_t;

    localparam sbps_word_t SBPS_WORD_RST = 16'h0000;

endpackage

// File: src/sbps_shift_reg.sv
// sixteen stage shift register: parallel load or serial shift on a
// falling edge of the pin clock, hold while chip select is high.
// assumes all pins are asynchronous to i_core_clk and that the pin clock
// is much slower than the core clock (each level lasts several core cycles).
`timescale 1ns/1ps
`default_nettype none

module sbps_shift_reg
    import sbps_pkg::*;
(
    // core clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    // pins from the host
    input  wire logic       i_falling_edge_clock,
    input  wire logic       i_chip_select_n,
    input  wire logic       i_load_select,
    input  wire logic       i_serial_in,
    input  wire sbps_word_t i_parallel_word_inputs,
    // serial output
    output logic            o_serial_out
);

    // what an accepted pin clock edge does in this cycle
    typedef enum logic [1:0]
    {
        SBPS_MODE_IDLE,
        SBPS_MODE_HOLD,
        SBPS_MODE_SHIFT,
        SBPS_MODE_LOAD
    } sbps_mode_t;

    // pin synchronisers
    sbps_ctrl_t ctrl_meta_q;
    sbps_ctrl_t ctrl_meta_d;
    sbps_ctrl_t ctrl_sync_q;
    sbps_ctrl_t ctrl_sync_d;
    sbps_word_t par_meta_q;
    sbps_word_t par_meta_d;
    sbps_word_t par_sync_q;
    sbps_word_t par_sync_d;

    // pin clock edge and mode
    logic       clk_prev_q;
    logic       clk_prev_d;
    logic       selected;
    logic       fall_edge;
    sbps_mode_t mode;

    // register stages and output copy
    sbps_word_t shift_src;
    sbps_word_t stage_q;
    sbps_word_t stage_d;
    logic       serial_out_q;
    logic       serial_out_d;

    // first synchroniser stage; it feeds only the second
    always_comb
    begin
        ctrl_meta_d = '{
            chip_select_n      : i_chip_select_n,
            load_select        : i_load_select,
            falling_edge_clock : i_falling_edge_clock,
            serial_in          : i_serial_in
        };
    end

    // control levels reset to idle: deselected, clock low, no false edge
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            ctrl_meta_q <= SBPS_CTRL_RST;
        end
        else
        begin
            ctrl_meta_q <= ctrl_meta_d;
        end
    end

    always_comb
    begin
        ctrl_sync_d = ctrl_meta_q;
    end

    // second stage; only this copy is read by the logic
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            ctrl_sync_q <= SBPS_CTRL_RST;
        end
        else
        begin
            ctrl_sync_q <= ctrl_sync_d;
        end
    end

    always_comb
    begin
        par_meta_d = i_parallel_word_inputs;
        par_sync_d = par_meta_q;
    end

    // data word needs no reset, it is only used on a load edge
    always_ff @(posedge i_core_clk)
    begin
        par_meta_q <= par_meta_d;
        par_sync_q <= par_sync_d;
    end

    // edge seen regardless of select; select only decides whether it acts
    always_comb
    begin
        clk_prev_d = ctrl_sync_q.falling_edge_clock;
        selected   = !ctrl_sync_q.chip_select_n;
        fall_edge  = clk_prev_q & ~ctrl_sync_q.falling_edge_clock;
    end

    // previous level resets to the idle level of the pin clock
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            clk_prev_q <= SBPS_CLK_RST;
        end
        else
        begin
            clk_prev_q <= clk_prev_d;
        end
    end

    // deselect wins over any edge and either mode level
    always_comb
    begin
        if (!selected)
        begin
            mode = SBPS_MODE_HOLD;
        end
        else if (!fall_edge)
        begin
            mode = SBPS_MODE_IDLE;
        end
        else if (ctrl_sync_q.load_select)
        begin
            mode = SBPS_MODE_LOAD;
        end
        else
        begin
            mode = SBPS_MODE_SHIFT;
        end
    end

    // stage fifteen has no successor, so the top bit simply drops out
    always_comb
    begin
        shift_src = {stage_q[SBPS_WIDTH-2:0], ctrl_sync_q.serial_in};
    end

    // one slice per stage
    for (genvar gi = 0; gi < SBPS_WIDTH; gi++)
    begin : g_stage
        always_comb
        begin
            unique case (mode)
                SBPS_MODE_LOAD:
                begin
                    stage_d[gi] = par_sync_q[gi];
                end
                SBPS_MODE_SHIFT:
                begin
                    stage_d[gi] = shift_src[gi];
                end
                SBPS_MODE_IDLE:
                begin
                    stage_d[gi] = stage_q[gi];
                end
                SBPS_MODE_HOLD:
                begin
                    stage_d[gi] = stage_q[gi];
                end
            endcase
        end
    end

    // stages deliberately not reset, like the part itself
    always_ff @(posedge i_core_clk)
    begin
        stage_q <= stage_d;
    end

    // copy taken from the next value, so it moves on the same edge as stage fifteen
    always_comb
    begin
        serial_out_d = stage_d[SBPS_LAST_STAGE];
    end

    // output must be driven from reset, so only this copy is reset
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            serial_out_q <= SBPS_WORD_RST[SBPS_LAST_STAGE];
        end
        else
        begin
            serial_out_q <= serial_out_d;
        end
    end

    assign o_serial_out = serial_out_q;

endmodule

`default_nettype wire

// File: dv/sbps_chk.sv
// checker on the shift register ports
// assumes pins change well apart from the core edges
`timescale 1ns/1ps
`default_nettype none
module sbps_chk
    import sbps_pkg::*;
(
    // core clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    // pins from the host
    input  wire logic       i_falling_edge_clock,
    input  wire logic       i_chip_select_n,
    input  wire logic       i_load_select,
    input  wire logic       i_serial_in,
    input  wire sbps_word_t i_parallel_word_inputs,
    // serial output
    input  wire logic       o_serial_out
);
    logic       pclk_prev_q;
    logic       pin_fall;
    sbps_word_t shadow_q;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    always_comb
    begin
        pin_fall = pclk_prev_q & ~i_falling_edge_clock;
    end
    // pin-level model of the stages, moved on each selected falling edge
    always_ff @(posedge i_core_clk)
    begin
        pclk_prev_q <= i_falling_edge_clock;
        if (pin_fall && !i_chip_select_n)
        begin
            shadow_q <= i_load_select ? i_parallel_word_inputs
                : {shadow_q[SBPS_WIDTH-2:0], i_serial_in};
        end
    end
    chk_load_top: assert property (($fell(i_falling_edge_clock) && !i_chip_select_n
        && i_load_select) |-> ##4 o_serial_out == $past(i_parallel_word_inputs[15], 4))
        else $error("load missed");
    chk_cs_hold: assert property (i_chip_select_n[*6] |-> $stable(o_serial_out))
        else $error("moved in hold");
    // six low samples cover the sync and edge latency
    chk_edge_only: assert property ((!i_falling_edge_clock)[*6] |-> $stable(o_serial_out))
        else $error("moved with no edge");
    chk_stage_model: assert property (pin_fall && !i_chip_select_n
        |-> ##4 o_serial_out == shadow_q[SBPS_LAST_STAGE])
        else $error("stage model differs");
    chk_cs_fall: assert property ($fell(i_falling_edge_clock) && i_chip_select_n
        && $past(i_chip_select_n, 3) |-> ##3 $stable(o_serial_out))
        else $error("edge acted while deselected");
    chk_out_change: assert property ($changed(o_serial_out) && !$past(i_sys_rst, 2)
        |-> $past(i_falling_edge_clock, 4) && !$past(i_falling_edge_clock, 3)
            && !$past(i_chip_select_n, 3))
        else $error("output moved with no edge");
    cov_load: cover property ($fell(i_falling_edge_clock) && !i_chip_select_n && i_load_select);
    cov_shift: cover property ($fell(i_falling_edge_clock) && !i_chip_select_n && !i_load_select);
    cov_hold: cover property ($fell(i_falling_edge_clock) && i_chip_select_n);
endmodule
bind sbps_shift_reg sbps_chk u_chk (.*);
`default_nettype wire

// File: dv/sbps_host.sv
// host model: one pin clock pulse per request
// assumes requests at least eight core cycles apart
`timescale 1ns/1ps
`default_nettype none
module sbps_host (
    input  wire logic i_core_clk,
    input  wire logic i_req,
    output logic      o_pin_clk
);
    logic [2:0] cnt_q = 3'h0;
    always @(posedge i_core_clk)
    begin
        if (i_req) cnt_q <= 3'h4;
        else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    end
    // idle low, so raising chip select never makes an edge
    assign o_pin_clk = (cnt_q != 3'h0);
endmodule
`default_nettype wire

// File: dv/tb_sbps_shift_reg.sv
// self-checking bench with a queue model of the stages
// assumes the host model pulses the pin clock
`timescale 1ns/1ps
`default_nettype none
module tb_sbps_shift_reg;
    logic        clk = 1'b0, rst = 1'b1, cs_n = 1'b1, load = 1'b0, si = 1'b0, req = 1'b0;
    logic        so, pclk;
    logic [15:0] word = 16'h0000;
    logic        m [$];
    int          n_mismatch = 0, total_checks = 0;
    always #25 clk = ~clk;
    sbps_shift_reg u_sbps_shift_reg (.i_core_clk(clk), .i_sys_rst(rst),
        .i_falling_edge_clock(pclk), .i_chip_select_n(cs_n), .i_load_select(load),
        .i_serial_in(si), .i_parallel_word_inputs(word), .o_serial_out(so));
    sbps_host u_sbps_host (.i_core_clk(clk), .i_req(req), .o_pin_clk(pclk));
    task check(input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task op(input logic c, input logic l);
        @(posedge clk);
        {cs_n, load, si, word, req} <= {c, l, 1'($urandom), 16'($urandom), 1'b1};
        @(posedge clk) req <= 1'b0;
        // fixed wait covers sync plus edge latency
        repeat (12) @(posedge clk);
        if (!c && l) foreach (m[i]) m[i] = word[i];
        else if (!c)
        begin
            m.push_front(si);
            void'(m.pop_back());
        end
        check(so, m[15]);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (16) m.push_back(1'b0);
        void'($urandom(89));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        op(1'b0, 1'b1);
        repeat (80) op($urandom_range(3) == 0, $urandom_range(3) == 0);
        // a long unbroken run of shifts carries serial bits through to the output
        repeat (20) op(1'b0, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
